/* core/ana_pkg.sv */
// Constants, register indices and field layout of the ability register bank.
// Assumes APB word addressing: byte address is four times the register index.
package ana_pkg;

  // Register indices; byte address is index times four.
  localparam logic [7:0]  ANA_IDX_ADVERT   = 8'h04;
  localparam logic [7:0]  ANA_IDX_PARTNER  = 8'h05;
  localparam logic [7:0]  ANA_IDX_NPVIEW   = 8'h08;
  localparam logic [7:0]  ANA_IDX_IRQ_STAT = 8'h09;
  localparam logic [7:0]  ANA_IDX_IRQ_MASK = 8'h0A;

  // Field positions shared by advertised and received ability words.
  localparam int          ANA_BIT_NP   = 15;
  localparam int          ANA_BIT_ACK  = 14;
  localparam int          ANA_BIT_RF   = 13;
  localparam int          ANA_BIT_T4   = 9;
  localparam int          ANA_SEL_LSB  = 0;
  localparam int          ANA_SEL_MSB  = 4;

  // Selector code of the IEEE 802.3u protocol family.
  localparam logic [4:0]  ANA_SEL_8023U = 5'h01;

  // Writable bits of the local advertisement word; bit 14, bits 12:11 and bit 9 read zero.
  localparam logic [15:0] ANA_ADV_WR_MASK = 16'hA5FF;
  // Partner word bits kept; bits 12:10 are reserved and read zero.
  localparam logic [15:0] ANA_LP_KEEP_MASK = 16'hE3FF;
  localparam logic [15:0] ANA_LP_RESET     = 16'h0000;

  // Event bits of the interrupt status and mask registers.
  localparam int          ANA_EVT_W    = 3;
  localparam int          ANA_EVT_BASE = 0;
  localparam int          ANA_EVT_NEXT = 1;
  localparam int          ANA_EVT_RF   = 2;

  localparam logic [31:0] ANA_ZERO_WORD = 32'h0000_0000;

endpackage

/* core/ana_link_if.sv */
// Carrier between the register core, the partner capture unit and the interrupt unit.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ana_link_if;
  import ana_pkg::*;
  logic [15:0]          lp_base;
  logic [15:0]          lp_next;
  logic [ANA_EVT_W-1:0] evt;
  logic [ANA_EVT_W-1:0] clr;
  logic                 mask_we;
  logic [ANA_EVT_W-1:0] mask_wdata;
  logic [ANA_EVT_W-1:0] status;
  logic [ANA_EVT_W-1:0] mask;
  logic                 irq;

  modport core (input lp_base, lp_next, evt, status, mask, irq,
                output clr, mask_we, mask_wdata);
  modport cap  (output lp_base, lp_next, evt);
  modport irqu (input evt, clr, mask_we, mask_wdata, output status, mask, irq);
endinterface
`default_nettype wire

/* core/ana_rx_capture.sv */
// Captures link partner base and next-page words delivered by the negotiation logic.
// Assumes word, valid and acknowledge inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ana_rx_capture
  import ana_pkg::*;
#(
  parameter bit NP_REPLACES_BASE = 1'b1
) (
  // Clock, reset and enable.
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  // Received words from the negotiation logic.
  input  wire logic [15:0] rx_word_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_next_page_in,
  input  wire logic        an_complete_in,
  input  wire logic        lp_ack_in,
  // Toward the register core.
  ana_link_if.cap          lnk
);
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] next;
    logic [ANA_EVT_W-1:0] evt;
  } ana_cap_st_t;

  ana_cap_st_t st_q;
  ana_cap_st_t st_d;
  logic [15:0] word_kept;

  always_comb begin
    st_d      = st_q;
    st_d.evt  = '0;
    word_kept = rx_word_in & ANA_LP_KEEP_MASK;
    if (rx_valid_in && !rx_next_page_in) begin
      st_d.base = word_kept;
      st_d.evt[ANA_EVT_BASE] = 1'b1;
      st_d.evt[ANA_EVT_RF]   = word_kept[ANA_BIT_RF] & ~st_q.base[ANA_BIT_RF];
    end
    if (rx_valid_in && rx_next_page_in) begin
      st_d.next = rx_word_in;
      st_d.evt[ANA_EVT_NEXT] = 1'b1;
      // late base replacement
      // Next pages only overwrite the base view once negotiation has completed.
      if (NP_REPLACES_BASE && an_complete_in) begin
        st_d.base = word_kept;
      end
    end
    // acknowledge tracking
    // The acknowledge bit follows the negotiation logic, never software.
    st_d.base[ANA_BIT_ACK] = lp_ack_in;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_q <= '{base: ANA_LP_RESET, next: ANA_LP_RESET, evt: '0};
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign lnk.lp_base = st_q.base;
  assign lnk.lp_next = st_q.next;
  assign lnk.evt     = st_q.evt;
endmodule // ana_rx_capture
`default_nettype wire

/* core/ana_irq.sv */
// Sticky event status, mask and level interrupt for the ability register bank.
// Assumes single-cycle event pulses and write strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ana_irq
  import ana_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  // Events, strobes and results.
  ana_link_if.irqu  lnk
);
  typedef struct packed {
    logic [ANA_EVT_W-1:0] status;
    logic [ANA_EVT_W-1:0] mask;
  } ana_irq_st_t;

  ana_irq_st_t st_q;
  ana_irq_st_t st_d;

  always_comb begin
    st_d = st_q;
    // An event in the clearing cycle survives: set is applied after clear.
    st_d.status = (st_q.status & ~lnk.clr) | lnk.evt;
    if (lnk.mask_we) begin
      st_d.mask = lnk.mask_wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_q <= '{status: '0, mask: '0};
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign lnk.status = st_q.status;
  assign lnk.mask   = st_q.mask;
  assign lnk.irq    = |(st_q.status & st_q.mask);
endmodule // ana_irq
`default_nettype wire

/* core/ana_regs.sv */
// Auto-negotiation ability register bank with APB slave and interrupt.
// Assumes a negotiation engine on the same clock supplies received words and acknowledge.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Advertisement bit 15 requests further page exchange when set.
// - Advertisement bit 13 advertises a locally detected remote fault.
// - Advertisement bit 14 ignores writes and reads zero.
// - Advertisement contents are sent to the partner as our abilities.
// - Partner register captures received abilities and is read-only.
// - With next pages, partner contents may change after negotiation completes.
// - Partner bit 15 shows the partner's next-page request.
// - Negotiation logic drives partner acknowledge bit 14 by itself.
// - Partner bit 14 reads one once the partner acknowledged our word.
// - Partner bit 13 shows partner remote fault; resets to zero.
// - Partner bits 12 to 10 always read zero.
// - Partner bit 9 shows 100BASE-T4 ability.
// - Partner bit 8 shows 100BASE-TX full duplex ability.
// - Partner bit 7 shows 100BASE-TX ability.
// - Partner bit 6 shows 10BASE-T full duplex ability.
// - Partner bit 5 shows 10BASE-T ability.
// - Selector 00001 in bits 4 to 0 identifies IEEE 802.3u.
module ana_regs
  import ana_pkg::*;
#(
  parameter logic [15:0] ADV_RESET        = 16'h01E1,
  parameter bit          NP_REPLACES_BASE = 1'b1,
  parameter int          ADDR_W           = 12
) (
  // Clock, reset and enable.
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  // APB slave.
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  // Negotiation engine side.
  input  wire logic [15:0]       rx_word_in,
  input  wire logic              rx_valid_in,
  input  wire logic              rx_next_page_in,
  input  wire logic              an_complete_in,
  input  wire logic              lp_ack_in,
  output logic [15:0]            tx_advert_out,
  // Interrupt.
  output logic                   irq_out
);

  generate
    if ((ADV_RESET & ~ANA_ADV_WR_MASK) != 16'h0000) begin : g_bad_reset
      $error("ADV_RESET sets a bit that must read zero");
    end
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 10 and 32");
    end
  endgenerate

  // Matches a byte address against a register index.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return addr == ADDR_W'({idx, 2'b00});
  endfunction

  // True when the address decodes to any register of the bank.
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    return reg_hit(addr, ANA_IDX_ADVERT) || reg_hit(addr, ANA_IDX_PARTNER) ||
           reg_hit(addr, ANA_IDX_NPVIEW) || reg_hit(addr, ANA_IDX_IRQ_STAT) ||
           reg_hit(addr, ANA_IDX_IRQ_MASK);
  endfunction

  typedef struct packed {
    logic [15:0] advert;
    logic [31:0] rdata;
  } ana_core_st_t;

  ana_core_st_t st_q;
  ana_core_st_t st_d;

  ana_link_if lnk ();

  ana_rx_capture #(
    .NP_REPLACES_BASE (NP_REPLACES_BASE)
  ) u_cap (
    .mclk_in         (mclk_in),
    .sys_rst_in      (sys_rst_in),
    .ce_in           (ce_in),
    .rx_word_in      (rx_word_in),
    .rx_valid_in     (rx_valid_in),
    .rx_next_page_in (rx_next_page_in),
    .an_complete_in  (an_complete_in),
    .lp_ack_in       (lp_ack_in),
    .lnk             (lnk.cap)
  );

  ana_irq u_irq (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .lnk        (lnk.irqu)
  );

  logic        setup_ph;
  logic        wr_acc;
  logic [15:0] wr_lanes;
  logic [15:0] adv_wr;

  assign setup_ph = psel_in && !penable_in;
  assign wr_acc   = psel_in && penable_in && pwrite_in && ce_in;
  assign wr_lanes = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign adv_wr   = (st_q.advert & ~wr_lanes) | (pwdata_in[15:0] & wr_lanes);

  always_comb begin
    st_d = st_q;
    lnk.clr        = '0;
    lnk.mask_we    = 1'b0;
    lnk.mask_wdata = pwdata_in[ANA_EVT_W-1:0];
    // Read data is fetched in the setup cycle so it leaves a flip-flop in the access cycle.
    if (setup_ph) begin
      st_d.rdata = ANA_ZERO_WORD;
      if (reg_hit(paddr_in, ANA_IDX_ADVERT)) begin
        st_d.rdata[15:0] = st_q.advert;
      end
      if (reg_hit(paddr_in, ANA_IDX_PARTNER)) begin
        st_d.rdata[15:0] = lnk.lp_base;
      end
      if (reg_hit(paddr_in, ANA_IDX_NPVIEW)) begin
        st_d.rdata[15:0] = lnk.lp_next;
      end
      if (reg_hit(paddr_in, ANA_IDX_IRQ_STAT)) begin
        st_d.rdata[ANA_EVT_W-1:0] = lnk.status;
      end
      if (reg_hit(paddr_in, ANA_IDX_IRQ_MASK)) begin
        st_d.rdata[ANA_EVT_W-1:0] = lnk.mask;
      end
    end
    if (wr_acc) begin
      if (reg_hit(paddr_in, ANA_IDX_ADVERT)) begin
        st_d.advert = adv_wr & ANA_ADV_WR_MASK;
      end
      if (reg_hit(paddr_in, ANA_IDX_IRQ_STAT) && pstrb_in[0]) begin
        lnk.clr = pwdata_in[ANA_EVT_W-1:0];
      end
      if (reg_hit(paddr_in, ANA_IDX_IRQ_MASK) && pstrb_in[0]) begin
        lnk.mask_we = 1'b1;
      end
      // partner writes ignored
      // Writes to the partner views fall through without effect or error.
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_q <= '{advert: ADV_RESET, rdata: ANA_ZERO_WORD};
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // A frozen bank must not complete transfers, so ready follows the enable.
  assign pready_out  = ce_in;
  assign pslverr_out = psel_in && penable_in && !reg_mapped(paddr_in);
  assign prdata_out  = st_q.rdata;
  assign tx_advert_out = st_q.advert;
  assign irq_out       = lnk.irq;

  logic base_load;
  assign base_load = rx_valid_in && ce_in &&
                     (!rx_next_page_in || (NP_REPLACES_BASE && an_complete_in));

  chk_adv_np_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_acc && reg_hit(paddr_in, ANA_IDX_ADVERT) && pstrb_in[1]
    |=> tx_advert_out[ANA_BIT_NP] == $past(pwdata_in[ANA_BIT_NP]))
    else $error("next page request bit not written");

  chk_adv_rf_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_acc && reg_hit(paddr_in, ANA_IDX_ADVERT) && pstrb_in[1]
    |=> tx_advert_out[ANA_BIT_RF] == $past(pwdata_in[ANA_BIT_RF]))
    else $error("remote fault advertise bit not written");

  chk_adv_rsv_read: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    psel_in && penable_in && reg_hit(paddr_in, ANA_IDX_ADVERT)
    |-> prdata_out[ANA_BIT_ACK] == 1'b0 && prdata_out[31:16] == 16'h0000)
    else $error("reserved advertisement bits read nonzero");

  chk_adv_low_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_acc && reg_hit(paddr_in, ANA_IDX_ADVERT) && pstrb_in[0]
    |=> tx_advert_out[7:0] == ($past(pwdata_in[7:0]) & ANA_ADV_WR_MASK[7:0]))
    else $error("advertised low byte does not follow write");

  chk_lp_load: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    base_load |=> lnk.lp_base[9:0] == ($past(rx_word_in[9:0]) & ANA_LP_KEEP_MASK[9:0]))
    else $error("partner abilities not captured");

  chk_lp_np_replace: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_valid_in && rx_next_page_in && ce_in && !an_complete_in
    |=> $stable({lnk.lp_base[ANA_BIT_NP], lnk.lp_base[ANA_BIT_RF:ANA_SEL_LSB]}))
    else $error("partner view changed before negotiation completed");

  chk_lp_np_bit: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    base_load ##1 !rx_valid_in[*2] |-> lnk.lp_base[ANA_BIT_NP] == $past(rx_word_in[ANA_BIT_NP], 2))
    else $error("partner next page bit wrong");

  chk_lp_ack_track: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ce_in |=> lnk.lp_base[ANA_BIT_ACK] == $past(lp_ack_in))
    else $error("partner acknowledge bit does not follow negotiation");

  chk_lp_rf_reset: assert property (@(posedge mclk_in)
    sys_rst_in |=> lnk.lp_base[ANA_BIT_RF] == 1'b0 && lnk.lp_next == 16'h0000)
    else $error("partner remote fault not cleared by reset");

  chk_lp_rsv_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    lnk.lp_base[12:10] == 3'h0)
    else $error("partner reserved bits nonzero");

  chk_lp_tech_bits: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    base_load |=> lnk.lp_base[ANA_BIT_T4:5] == $past(rx_word_in[ANA_BIT_T4:5]))
    else $error("partner technology bits wrong");

  chk_adv_sel_reset: assert property (@(posedge mclk_in)
    sys_rst_in |=> tx_advert_out[ANA_SEL_MSB:ANA_SEL_LSB] == ADV_RESET[ANA_SEL_MSB:ANA_SEL_LSB])
    else $error("advertised selector wrong after reset");

  chk_lp_sel_load: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    base_load |=> lnk.lp_base[ANA_SEL_MSB:ANA_SEL_LSB] ==
                  $past(rx_word_in[ANA_SEL_MSB:ANA_SEL_LSB]))
    else $error("partner selector not loaded");

  chk_irq_event: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ce_in && lnk.evt[ANA_EVT_BASE] && lnk.mask[ANA_EVT_BASE] && !lnk.mask_we |=> irq_out)
    else $error("unmasked event did not raise interrupt");

  chk_apb_unmapped: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    setup_ph && !reg_mapped(paddr_in) ##1 penable_in |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");

endmodule // ana_regs
`default_nettype wire

/* tb/ana_link_partner.sv */
// Behavioural link partner: delivers received code words and acknowledge.
// Assumes the bench calls its tasks from one process, right after an edge.
`timescale 1ns/1ps
`default_nettype none
module ana_link_partner (
  // Clock.
  input  wire logic   mclk_in,
  // Toward the device.
  output logic [15:0] rx_word_out,
  output logic        rx_valid_out,
  output logic        rx_next_page_out,
  output logic        an_complete_out,
  output logic        lp_ack_out
);
  initial begin
    rx_word_out = 16'h0000;
    rx_valid_out = 1'b0;
    rx_next_page_out = 1'b0;
    an_complete_out = 1'b0;
    lp_ack_out = 1'b0;
  end
  // one word per pulse.
  // The stale word is inverted so that a late capture cannot pass by luck.
  task automatic send(input logic [15:0] w, input logic np, input logic done);
    @(posedge mclk_in);
    rx_word_out <= w;
    rx_valid_out <= 1'b1;
    rx_next_page_out <= np;
    an_complete_out <= done;
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_word_out <= ~w;
  endtask
  task automatic ack(input logic a);
    @(posedge mclk_in);
    lp_ack_out <= a;
  endtask
endmodule // ana_link_partner
`default_nettype wire

/* tb/test_autoneg_ability_registers.sv */
// Self-checking bench for the ability register bank: APB master, model, partner.
// Assumes ana_pkg, ana_link_if and the design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_autoneg_ability_registers;
  import ana_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, irq, rxv, rxnp, ancmp, ack;
  logic [31:0] prdata, rd;
  logic [15:0] rxw, txadv, w;
  logic [15:0] lf = 16'h0040;
  logic        err;
  int          mismatches = 0;
  int          tests_run = 0;
  int          adv, lp, m;
  int          lp_q[$];
  always #5 clk = ~clk;
  ana_regs u_dut (.mclk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .rx_word_in(rxw), .rx_valid_in(rxv), .rx_next_page_in(rxnp),
    .an_complete_in(ancmp), .lp_ack_in(ack), .tx_advert_out(txadv), .irq_out(irq));
  ana_link_partner u_lp (.mclk_in(clk), .rx_word_out(rxw), .rx_valid_out(rxv),
    .rx_next_page_out(rxnp), .an_complete_out(ancmp), .lp_ack_out(ack));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("mismatch pready expected 1 seen timeout");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // The interrupt is looked at two edges later, once status and mask have settled.
  task automatic irqchk(input string nm, input logic e);
    repeat (2) @(posedge clk);
    chk(nm, {31'h0, e}, {31'h0, irq});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("mismatch watchdog expected end seen hang");
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    adv = 32'h01E1;
    lp = 0;
    rdchk("advert", 12'h010, adv);
    chk("tx_advert", adv, {16'h0000, txadv});
    rdchk("partner", 12'h014, 32'h0000_0000);
    rdchk("npview", 12'h020, 32'h0000_0000);
    rdchk("irq_stat", 12'h024, 32'h0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      w = (i == 0) ? 16'hFFFF : lf;
      m = (i == 7) ? 32'hFF00 : 32'hFFFF;
      pstrb <= (i == 7) ? 4'h2 : 4'hF;
      apb(1'b1, 12'h010, {16'hFFFF, w});
      adv = (adv & ~(m & ANA_ADV_WR_MASK)) | (w & m & ANA_ADV_WR_MASK);
      rdchk("advert", 12'h010, adv);
      chk("tx_advert", adv, {16'h0000, txadv});
    end
    pstrb <= 4'hF;
    $display("test advertisement done");
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0001 : lf;
      u_lp.ack(lf[0]);
      u_lp.send(w, 1'b0, 1'b0);
      lp_q.push_back((w & 32'hA3FF) | (lf[0] ? 32'h4000 : 0));
      apb(1'b1, 12'h014, 32'hFFFF_FFFF);
      chk("partner_wr_err", 32'h0, {31'h0, err});
      lp = lp_q.pop_front();
      rdchk("partner", 12'h014, lp);
    end
    $display("test partner base page done");
    lf = lfsr(lf);
    u_lp.send(lf, 1'b1, 1'b0);
    rdchk("npview", 12'h020, lf);
    rdchk("partner", 12'h014, lp);
    lf = lfsr(lf);
    u_lp.send(lf, 1'b1, 1'b1);
    lp = (lf & 32'hA3FF) | (lp & 32'h4000);
    rdchk("npview", 12'h020, lf);
    rdchk("partner", 12'h014, lp);
    $display("test next page done");
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    chk("unmapped_wr_err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("unmapped_rd_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    rdchk("advert", 12'h010, adv);
    $display("test unmapped done");
    apb(1'b1, 12'h024, 32'h0000_0007);
    apb(1'b1, 12'h028, 32'h0000_0002);
    u_lp.send(16'h0000, 1'b0, 1'b0);
    u_lp.send(16'h2000, 1'b0, 1'b0);
    irqchk("irq_masked", 1'b0);
    rdchk("irq_stat", 12'h024, 32'h0000_0005);
    apb(1'b1, 12'h028, 32'h0000_0004);
    irqchk("irq_rf", 1'b1);
    apb(1'b1, 12'h024, 32'h0000_0004);
    irqchk("irq_clr", 1'b0);
    rdchk("irq_stat", 12'h024, 32'h0000_0001);
    rdchk("irq_mask", 12'h028, 32'h0000_0004);
    $display("test interrupt done");
    // Reset clears the acknowledge bit, but it follows the partner again right after reset, so drop it first.
    u_lp.ack(1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("advert", 12'h010, 32'h0000_01E1);
    rdchk("partner", 12'h014, 32'h0000_0000);
    rdchk("irq_mask", 12'h028, 32'h0000_0000);
    $display("test second reset done");
    summarize();
  end
endmodule // test_autoneg_ability_registers
`default_nettype wire
